// file: rtl/bfifo_host.sv
/*
 Host controller for a 16-word fall-through store, plus its 32-word
 staging buffer. Assumes the device pins are wired straight to dev_o and
 dev_i and that nothing else drives the load or unload strobes.
*/
// Behaviour
// [R1] Pulse clear low after reset before use
// [R2] Device raises input ready when first cell empty
// [R3] Device loads only with both load clocks high
// [R4] Device pulses input ready and unload out low
// [R5] Device ripples words down to empty cells
// [R6] Device keeps input ready low when full
// [R7] Never load while input ready is low
// [R8] Device ignores loads until input ready high
// [R9] Device pulses unload out when word falls
// [R10] Device raises output ready on valid word
// [R11] Unload only while output ready high, strobe low
// [R12] Device drops output ready during unload low
// [R13] Device frees last cell on unload low; the model frees it on unload high
// [R14] Device refills output on unload rising edge
// [R15] Device holds last word when emptied
// [R16] Device flags full and empty by hold times
// [R17] Cascade via unload out driving next load
// [R18] Cascade timing applies beyond sixteen words
// [R19] Device keeps five bits in arrival order
// [R20] Device floats outputs when enable is high; the model drives the inverted word instead
`timescale 1ns/1ps

module bfifo_sync_buf #(
   parameter int unsigned WIDTH = 5,
   parameter int unsigned DEPTH = 32
) (
   input  wire logic             mclk,
   input  wire logic             nrst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int unsigned PW = $clog2(DEPTH);
   localparam int unsigned CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];   // Word storage
   logic [PW-1:0]    wr_ptr_reg;    // Next slot to fill
   logic [PW-1:0]    wr_ptr_next;
   logic [PW-1:0]    rd_ptr_reg;    // Oldest word
   logic [PW-1:0]    rd_ptr_next;
   logic [CW-1:0]    count_reg;     // Words held
   logic [CW-1:0]    count_next;
   logic             ready_reg;     // Registered room flag
   logic             ready_next;
   logic             push;
   logic             pop;

   assign in_ready  = ready_reg;
   assign out_valid = (count_reg != '0);
   assign out_data  = mem[rd_ptr_reg];

   // Pointer and count arithmetic, wrapping at the depth
   always_comb begin
      push        = in_valid && ready_reg;
      pop         = out_valid && out_ready;
      wr_ptr_next = wr_ptr_reg;
      rd_ptr_next = rd_ptr_reg;
      count_next  = count_reg;
      if (push) begin
         wr_ptr_next = (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
         rd_ptr_next = (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
         count_next = count_reg + 1'b1;
      end else if (pop && !push) begin
         count_next = count_reg - 1'b1;
      end
      // Ready registered from the next count: no slot is lost, and it stays a flop
      ready_next = (count_next != CW'(DEPTH));
   end

   // State registers
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
         ready_reg  <= 1'b0;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         count_reg  <= count_next;
         ready_reg  <= ready_next;
      end
   end

   // Storage has no reset; only written slots are ever read
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end
endmodule

module bfifo_host (
   input  wire logic                                mclk,
   input  wire logic                                nrst,
   input  wire logic                                wr_valid,
   output logic                                     wr_ready,
   input  wire logic [bfifo_host_pkg::WORD_W-1:0]   wr_data,
   output logic                                     rd_valid,
   input  wire logic                                rd_ready,
   output logic      [bfifo_host_pkg::WORD_W-1:0]   rd_data,
   output bfifo_host_pkg::dev_drive_t               dev_o,
   input  wire bfifo_host_pkg::dev_sense_t          dev_i,
   output logic                                     dev_full,
   output logic                                     dev_empty,
   output logic                                     init_done
);
   typedef enum {ST_CLEAR, ST_RECOVER, LD_IDLE, LD_SETUP, LD_HIGH,
                 LD_HOLD, LD_WAIT} ld_state_t;
   typedef enum {RD_IDLE, RD_LOW, RD_GAP} rd_state_t;

   bfifo_host_pkg::dev_sense_t sense_m_reg;   // First sync stage only
   bfifo_host_pkg::dev_sense_t sense_s_reg;   // Safe sampled pins
   bfifo_host_pkg::dev_drive_t drv_reg;       // Pins driven out
   bfifo_host_pkg::dev_drive_t drv_next;
   ld_state_t                  ld_reg;        // Clear and load sequencer
   ld_state_t                  ld_next;
   logic [7:0]                 ld_cnt_reg;
   logic [7:0]                 ld_cnt_next;
   rd_state_t                  rd_reg;        // Unload sequencer
   rd_state_t                  rd_next;
   logic [7:0]                 rd_cnt_reg;
   logic [7:0]                 rd_cnt_next;
   logic                       rdv_reg;       // Word held for the user
   logic                       rdv_next;
   logic [bfifo_host_pkg::WORD_W-1:0] rdd_reg;
   logic [bfifo_host_pkg::WORD_W-1:0] rdd_next;
   logic [7:0]                 ir_lo_reg;     // Cycles input ready low
   logic [7:0]                 ir_lo_next;
   logic [7:0]                 or_lo_reg;     // Cycles output ready low
   logic [7:0]                 or_lo_next;
   logic                       full_reg;
   logic                       full_next;
   logic                       empty_reg;
   logic                       empty_next;
   logic                       done_reg;
   logic                       done_next;
   logic                       buf_valid;     // Staged word waiting
   logic                       buf_pop;
   logic [bfifo_host_pkg::WORD_W-1:0] buf_data;
   logic                       ir_s;
   logic                       or_s;

   assign ir_s      = sense_s_reg.input_ready;
   assign or_s      = sense_s_reg.output_ready;
   assign dev_o     = drv_reg;
   assign rd_valid  = rdv_reg;
   assign rd_data   = rdd_reg;
   assign dev_full  = full_reg;
   assign dev_empty = empty_reg;
   assign init_done = done_reg;

   // Staging buffer; its ready stalls the writer when loads lag
   bfifo_sync_buf #(
      .WIDTH (bfifo_host_pkg::WORD_W),
      .DEPTH (bfifo_host_pkg::BUF_DEPTH)
   ) u_buf (
      .mclk      (mclk),
      .nrst      (nrst),
      .in_valid  (wr_valid),
      .in_ready  (wr_ready),
      .in_data   (wr_data),
      .out_valid (buf_valid),
      .out_ready (buf_pop),
      .out_data  (buf_data)
   );

   // Two-flop synchroniser for every device pin
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sense_m_reg <= '0;
         sense_s_reg <= '0;
      end else begin
         sense_m_reg <= dev_i;
         sense_s_reg <= sense_m_reg;
      end
   end

   // Next values of both sequencers and the status flags
   always_comb begin
      drv_next    = drv_reg;
      ld_next     = ld_reg;
      ld_cnt_next = ld_cnt_reg + 8'h01;
      rd_next     = rd_reg;
      rd_cnt_next = rd_cnt_reg + 8'h01;
      rdv_next    = rdv_reg && !rd_ready;
      rdd_next    = rdd_reg;
      done_next   = done_reg;
      buf_pop     = 1'b0;
      case (ld_reg)
         ST_CLEAR: begin
            // Clear held low for the full pulse width [R1]
            drv_next.clear_n = 1'b0;
            if (ld_cnt_reg == bfifo_host_pkg::CLEAR_CYC - 8'h01) begin
               drv_next.clear_n = 1'b1;
               ld_next          = ST_RECOVER;
               ld_cnt_next      = 8'h00;
            end
         end
         ST_RECOVER: begin
            // No strobe until the store has settled after clear [R1]
            if (ld_cnt_reg == bfifo_host_pkg::RECOVER_CYC - 8'h01) begin
               ld_next       = LD_IDLE;
               done_next     = 1'b1;
               drv_next.oe_n = 1'b0;
            end
         end
         LD_IDLE: begin
            // Present a word only while the device shows room [R7]
            ld_cnt_next = 8'h00;
            if (buf_valid && ir_s) begin
               buf_pop              = 1'b1;
               drv_next.data_in_bus = buf_data;
               ld_next              = LD_SETUP;
            end
         end
         LD_SETUP: begin
            // Data settles before both load clocks rise together
            if (ld_cnt_reg == bfifo_host_pkg::SETUP_CYC - 8'h01) begin
               drv_next.load_a = 1'b1;
               drv_next.load_b = 1'b1;
               ld_next         = LD_HIGH;
               ld_cnt_next     = 8'h00;
            end
         end
         LD_HIGH: begin
            if (ld_cnt_reg == bfifo_host_pkg::HIGH_CYC - 8'h01) begin
               drv_next.load_a = 1'b0;
               drv_next.load_b = 1'b0;
               ld_next         = LD_HOLD;
               ld_cnt_next     = 8'h00;
            end
         end
         LD_HOLD: begin
            // Data held past the clocks falling
            if (ld_cnt_reg == bfifo_host_pkg::HOLD_CYC - 8'h01) begin
               ld_next     = LD_WAIT;
               ld_cnt_next = 8'h00;
            end
         end
         LD_WAIT: begin
            // Stale high input ready must not start a second load [R7]
            // Unload out idles high; its low dip marks acceptance [R17]
            if (!ir_s || !sense_s_reg.unload_strobe_out ||
                ld_cnt_reg == bfifo_host_pkg::IR_WAIT_CYC - 8'h01) begin
               ld_next = LD_IDLE;
            end
         end
         default: begin
            ld_next = ST_CLEAR;
         end
      endcase
      case (rd_reg)
         RD_IDLE: begin
            // Take a word only while output ready is high [R11]
            rd_cnt_next = 8'h00;
            if (done_reg && or_s && !rdv_reg) begin
               drv_next.unload_strobe_in_n = 1'b0;
               rd_next                     = RD_LOW;
            end
         end
         RD_LOW: begin
            // Low long enough that a synced output ready has dropped
            if (rd_cnt_reg == bfifo_host_pkg::UNL_LOW_CYC - 8'h01) begin
               // Word taken late in the low phase: the device holds it
               // steady here, while data may trail output ready's rise
               rdd_next                    = sense_s_reg.data_out_bus;
               drv_next.unload_strobe_in_n = 1'b1;
               rdv_next                    = 1'b1;
               rd_next                     = RD_GAP;
               rd_cnt_next                 = 8'h00;
            end
         end
         RD_GAP: begin
            // Standalone refill time; cascades need longer [R18]
            if (rd_cnt_reg == bfifo_host_pkg::UNL_GAP_CYC - 8'h01) begin
               rd_next = RD_IDLE;
            end
         end
         default: begin
            rd_next = RD_IDLE;
         end
      endcase
      // Saturating low-time counters give full and empty status
      ir_lo_next = (ir_s || !done_reg) ? 8'h00 :
                   (ir_lo_reg == bfifo_host_pkg::BUBBLE_CYC) ? ir_lo_reg :
                   ir_lo_reg + 8'h01;
      or_lo_next = (or_s || !done_reg) ? 8'h00 :
                   (or_lo_reg == bfifo_host_pkg::FALL_CYC) ? or_lo_reg :
                   or_lo_reg + 8'h01;
      full_next  = (ir_lo_next == bfifo_host_pkg::BUBBLE_CYC);
      empty_next = (or_lo_next == bfifo_host_pkg::FALL_CYC);
   end

   // Registers of the sequencers and flags
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         drv_reg    <= bfifo_host_pkg::DRIVE_RESET;
         ld_reg     <= ST_CLEAR;
         ld_cnt_reg <= 8'h00;
         rd_reg     <= RD_IDLE;
         rd_cnt_reg <= 8'h00;
         rdv_reg    <= 1'b0;
         rdd_reg    <= 5'h00;
         ir_lo_reg  <= 8'h00;
         or_lo_reg  <= 8'h00;
         full_reg   <= 1'b0;
         empty_reg  <= 1'b0;
         done_reg   <= 1'b0;
      end else begin
         drv_reg    <= drv_next;
         ld_reg     <= ld_next;
         ld_cnt_reg <= ld_cnt_next;
         rd_reg     <= rd_next;
         rd_cnt_reg <= rd_cnt_next;
         rdv_reg    <= rdv_next;
         rdd_reg    <= rdd_next;
         ir_lo_reg  <= ir_lo_next;
         or_lo_reg  <= or_lo_next;
         full_reg   <= full_next;
         empty_reg  <= empty_next;
         done_reg   <= done_next;
      end
   end

   // Checks on the pin sequences
   a_clear_width: assert property (@(posedge mclk) disable iff (!nrst) // [R1]
      $rose(drv_reg.clear_n) |-> !$past(drv_reg.clear_n, 4))
      else $error("clear pulse too short");
   a_no_load_early: assert property ( // [R1]
      @(posedge mclk) disable iff (!nrst)
      !done_reg |-> !drv_reg.load_a && !drv_reg.load_b)
      else $error("load before clear finished");
   a_load_after_ir: assert property ( // [R7]
      @(posedge mclk) disable iff (!nrst)
      $rose(drv_reg.load_a) |-> $past(ir_s, 3))
      else $error("load started without input ready");
   a_load_pulse: assert property (@(posedge mclk) disable iff (!nrst) // [R3]
      $rose(drv_reg.load_a) |-> (drv_reg.load_a && drv_reg.load_b)[*3]
      ##1 !drv_reg.load_a)
      else $error("load pulse shape wrong");
   a_unload_after_or: assert property ( // [R11]
      @(posedge mclk) disable iff (!nrst)
      $fell(drv_reg.unload_strobe_in_n) |-> $past(or_s) && !$past(rdv_reg))
      else $error("unload without output ready");
   a_unload_width: assert property ( // [R11]
      @(posedge mclk) disable iff (!nrst)
      $fell(drv_reg.unload_strobe_in_n) |->
      !drv_reg.unload_strobe_in_n[*5] ##1 rdv_reg)
      else $error("unload pulse shape wrong");
   a_full_status: assert property (@(posedge mclk) disable iff (!nrst) // [R16]
      $rose(full_reg) |-> !$past(ir_s, 1) && !$past(ir_s, 29))
      else $error("full flag too early");
   c_load_done: cover property (@(posedge mclk) disable iff (!nrst)
      $fell(drv_reg.load_a));
   c_unload_done: cover property (@(posedge mclk) disable iff (!nrst)
      $rose(rdv_reg));
   c_dev_full: cover property (@(posedge mclk) disable iff (!nrst)
      $rose(full_reg));
   c_buf_stall: cover property (@(posedge mclk) disable iff (!nrst)
      wr_valid && !wr_ready);
endmodule

// file: shared/bfifo_host_pkg.sv
/*
 Shared constants and pin bundles for the host that drives a 16-word
 fall-through store through its load, unload and clear pins.
 Assumes a 100 MHz host clock and pins that are asynchronous to it.
*/
package bfifo_host_pkg;

   // Host clock period
   localparam int unsigned CLK_PERIOD_NS = 10;

   // Word width of the store and depth of the device itself
   localparam int unsigned WORD_W    = 5;
   localparam int unsigned DEV_DEPTH = 16;

   // Depth of the host side staging buffer
   localparam int unsigned BUF_DEPTH = 32;

   // Pin timing in nanoseconds
   localparam int unsigned CLEAR_PULSE_NS       = 40;
   localparam int unsigned CLEAR_RECOVER_NS     = 240;
   localparam int unsigned LOAD_SETUP_NS        = 20;
   localparam int unsigned LOAD_HIGH_NS         = 30;
   localparam int unsigned LOAD_HOLD_NS         = 80;
   localparam int unsigned IR_LOW_WAIT_NS       = 75;
   localparam int unsigned UNLOAD_LOW_NS        = 50;
   localparam int unsigned UNLOAD_GAP_NS        = 70;
   localparam int unsigned BUBBLE_BACK_TIME_NS  = 290;
   localparam int unsigned FALL_THROUGH_TIME_NS = 220;

   // Least time to whole cycles, never below one
   function automatic int unsigned cyc_up(input int unsigned ns);
      int unsigned c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c == 0) ? 1 : c;
   endfunction

   // Cycle counts derived from the times above
   localparam logic [7:0] CLEAR_CYC   = 8'(cyc_up(CLEAR_PULSE_NS));
   localparam logic [7:0] RECOVER_CYC = 8'(cyc_up(CLEAR_RECOVER_NS));
   localparam logic [7:0] SETUP_CYC   = 8'(cyc_up(LOAD_SETUP_NS));
   localparam logic [7:0] HIGH_CYC    = 8'(cyc_up(LOAD_HIGH_NS));
   localparam logic [7:0] HOLD_CYC    = 8'(cyc_up(LOAD_HOLD_NS));
   localparam logic [7:0] IR_WAIT_CYC = 8'(cyc_up(IR_LOW_WAIT_NS));
   localparam logic [7:0] UNL_LOW_CYC = 8'(cyc_up(UNLOAD_LOW_NS));
   localparam logic [7:0] UNL_GAP_CYC = 8'(cyc_up(UNLOAD_GAP_NS));
   localparam logic [7:0] BUBBLE_CYC  = 8'(cyc_up(BUBBLE_BACK_TIME_NS));
   localparam logic [7:0] FALL_CYC    = 8'(cyc_up(FALL_THROUGH_TIME_NS));

   // Pins the host drives into the device
   typedef struct packed {
      logic              clear_n;
      logic              load_a;
      logic              load_b;
      logic              unload_strobe_in_n;
      logic              oe_n;
      logic [WORD_W-1:0] data_in_bus;
   } dev_drive_t;

   // Reset value of the driven pins: clear held, strobes idle
   localparam dev_drive_t DRIVE_RESET = '{
      clear_n: 1'b0, load_a: 1'b0, load_b: 1'b0,
      unload_strobe_in_n: 1'b1, oe_n: 1'b1, data_in_bus: 5'h00};

   // Pins the host senses from the device
   typedef struct packed {
      logic              input_ready;
      logic              output_ready;
      logic              unload_strobe_out;
      logic [WORD_W-1:0] data_out_bus;
   } dev_sense_t;

endpackage

// file: tb/bfifo_dev_model.sv
/*
 Behavioural model of the 16-word fall-through store at the host's pins.
 Assumes the host drives the dev_drive_t bundle from 5 ns clock edges;
 internal ripple polls every 10 ns, so the two never share a time step.
*/
`timescale 1ns/1ps

module bfifo_dev_model #(
   parameter int unsigned RIPPLE_POLLS = 4  // Polls to move one word on
) (
   input  wire bfifo_host_pkg::dev_drive_t pins_i,
   output bfifo_host_pkg::dev_sense_t      pins_o,
   output logic [7:0]                      misuse_cnt
);
   logic [bfifo_host_pkg::WORD_W-1:0] q[$];           // Words behind output
   logic [bfifo_host_pkg::WORD_W-1:0] out_w = '0;     // Output stage word
   logic                              has_out = 1'b0; // Output stage full
   logic                              ir = 1'b0;      // Input ready pin
   logic                              orr = 1'b0;     // Output ready pin
   logic                              uo = 1'b1;      // Unload out, idle high
   logic                              ld_busy = 1'b0; // Load pulse running
   logic                              taken = 1'b0;   // Unload in progress
   int unsigned                       rip = 0;        // Ripple poll count

   // Released outputs show the inverse so a stale word cannot pass
   assign pins_o = {ir, orr, uo, pins_i.oe_n ? ~out_w : out_w};
   initial misuse_cnt = 8'h00;

   // Load only on both clocks high while ready; ready and unload out dip
   always @(posedge (pins_i.load_a & pins_i.load_b)) begin
      if (pins_i.clear_n && ir) begin
         q.push_back(pins_i.data_in_bus);
         ld_busy = 1'b1;
         ir = 1'b0;
         uo = 1'b0;
         #10 uo = 1'b1;
         #30 ld_busy = 1'b0;
      end
      else if (pins_i.clear_n) begin
         misuse_cnt++;
      end
   end

   // Internal ripple toward the output and the input ready level
   always #10 begin
      if (!pins_i.clear_n) begin
         q.delete();
         has_out = 1'b0;
         orr = 1'b0;
         ir = 1'b0;
         taken = 1'b0;
         rip = 0;
      end
      else begin
         if (!has_out && q.size() != 0 && pins_i.unload_strobe_in_n) begin
            rip++;
            if (rip >= RIPPLE_POLLS) begin
               out_w = q.pop_front();
               has_out = 1'b1;
               orr = 1'b1;
               rip = 0;
            end
         end
         ir = !ld_busy && (q.size() + has_out < 16);
      end
   end

   // Unload low drops output ready; the word stays on the outputs
   always @(negedge pins_i.unload_strobe_in_n) begin
      if (orr && pins_i.clear_n) begin
         orr = 1'b0;
         taken = 1'b1;
      end
      else if (pins_i.clear_n) begin
         misuse_cnt++;
      end
   end

   // Unload high frees the stage; the next word follows on the next ripple poll
   always @(posedge pins_i.unload_strobe_in_n) begin
      if (taken) begin
         has_out = 1'b0;
         taken = 1'b0;
         rip = RIPPLE_POLLS - 1;
      end
   end
endmodule

// file: tb/bfifo_host_tb.sv
/*
 Self-checking bench for the store host with a device model behind it.
 Assumes a 100 MHz clock; inputs change on falling edges only.
*/
`timescale 1ns/1ps

module bfifo_host_tb;
   localparam int W = bfifo_host_pkg::WORD_W;
   logic                       mclk, nrst, wr_valid, wr_ready;
   logic                       rd_valid, rd_ready, dev_full, dev_empty;
   logic                       init_done;
   logic [W-1:0]               wr_data, rd_data, last_w;
   bfifo_host_pkg::dev_drive_t dev_o;
   bfifo_host_pkg::dev_sense_t dev_i;
   logic [7:0]                 misuse_cnt;
   logic [W-1:0]               exp_q[$];  // Words owed to the reader
   int                         err_total = 0;
   int                         compares = 0;
   int                         cyc = 0;   // Cycles run, for the hang guard

   bfifo_host DUT (.mclk(mclk), .nrst(nrst), .wr_valid(wr_valid),
      .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
      .rd_ready(rd_ready), .rd_data(rd_data), .dev_o(dev_o),
      .dev_i(dev_i), .dev_full(dev_full), .dev_empty(dev_empty),
      .init_done(init_done));
   bfifo_dev_model model (.pins_i(dev_o), .pins_o(dev_i),
      .misuse_cnt(misuse_cnt));

   // Free-running clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // Hang guard: the whole run needs well under this many cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("Counts: %0d compares, %0d errors", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
      end
   endtask

   task automatic chk_word(input logic [W-1:0] got, input logic [W-1:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
      end
   endtask

   // Offer one word and hold it until the buffer takes it
   task automatic push(input logic [W-1:0] w);
      @(negedge mclk);
      wr_valid = 1'b1;
      wr_data = w;
      @(posedge mclk);
      while (wr_ready !== 1'b1) @(posedge mclk);
      exp_q.push_back(w);
      @(negedge mclk);
      wr_valid = 1'b0;
   endtask

   // Accept one word and compare it with the oldest one owed
   task automatic pull();
      @(negedge mclk);
      rd_ready = 1'b1;
      @(posedge mclk);
      while (rd_valid !== 1'b1) @(posedge mclk);
      chk_word(rd_data, exp_q[0]);
      last_w = exp_q.pop_front();
      @(negedge mclk);
      rd_ready = 1'b0;
   endtask

   // Reset 16 cycles, then the clear pulse and enable of the outputs
   task automatic do_reset();
      @(negedge mclk);
      nrst = 1'b0;
      repeat (16) @(negedge mclk);
      chk_bit(dev_o === bfifo_host_pkg::DRIVE_RESET, 1'b1);
      nrst = 1'b1;
      exp_q.delete();
      repeat (2) @(negedge mclk);
      chk_bit(dev_o.clear_n, 1'b0);
      repeat (40) if (init_done !== 1'b1) @(negedge mclk);
      chk_bit(init_done, 1'b1);
      chk_bit(dev_o.clear_n, 1'b1);
      chk_bit(dev_o.oe_n, 1'b0);
   endtask

   // Eight words in, one every other cycle, then out; the drained store holds the last
   task automatic t_stream();
      for (int i = 0; i < 8; i++) push(W'(i * 3 + 1));
      repeat (8) pull();
      repeat (30) @(negedge mclk);
      chk_bit(rd_valid, 1'b0);
      chk_bit(dev_i.output_ready, 1'b0);
      chk_word(dev_i.data_out_bus, last_w);
      chk_bit(dev_empty, 1'b1);
   endtask

   // Reader stalls: store and buffer fill until refused, then drain
   task automatic t_fill();
      for (int i = 0; i < 49; i++) push(W'(31 - i));
      repeat (200) @(negedge mclk);
      chk_bit(dev_i.input_ready, 1'b0);
      chk_bit(dev_full, 1'b1);
      chk_bit(wr_ready, 1'b0);
      repeat (49) pull();
      repeat (40) @(negedge mclk);
      chk_bit(dev_full, 1'b0);
      chk_bit(dev_empty, 1'b1);
   endtask

   // Reset in mid-run: the clear must leave no stale word behind
   task automatic t_midreset();
      for (int i = 0; i < 5; i++) push(W'(i + 8));
      repeat (60) @(negedge mclk);
      do_reset();
      for (int i = 0; i < 3; i++) push(W'(i + 26));
      repeat (3) pull();
      repeat (40) @(negedge mclk);
      chk_bit(rd_valid, 1'b0);
      chk_bit(misuse_cnt == 8'h00, 1'b1);
   endtask

   // Main sequence
   initial begin
      nrst = 1'b0;
      wr_valid = 1'b0;
      wr_data = '0;
      rd_ready = 1'b0;
      last_w = '0;
      do_reset();
      t_stream();
      t_fill();
      t_midreset();
      end_of_test();
   end
endmodule
